// File: pmd_duty.sv
// Purpose: per-period PID duty computation and PWM drive
// Assumes: inputs synchronous to ref_clk, Avalon-MM slave with waitrequest
// Notes: the pid multiply is done in one cycle, kept small by 8-bit gains
//
// Overview of operation
// - the raw input is held as a 12-bit unsigned value 0 to 4095.
// - the control period is set in 1 ms steps and the duty calculation runs once per period.
// - in pulse-width mode the raw input is the pulse width in 2/3 us units.
// - raw input is scaled into a target confined to 0 to 4095.
// - the raw feedback is held as a 12-bit unsigned value 0 to 4095.
// - scaled feedback runs from 0 at minimum to 4095 at maximum position.
// - current is an 8-bit sample with a separate amperes calibration constant.
// - each period the error is scaled feedback minus target, signed.
// - the controller sums proportional, integral and derivative terms.
// - the controller result is saturated to -600 to +600.
// - the duty target is reduced by acceleration, current and max duty limits.
// - the limited duty drives the pwm: +600 full forward, -600 full reverse.
// - with feedback off the duty target is the target minus 2048.
// - with feedback off all duty limits still apply.
// - the off command stops drive while all calculations continue.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module pmd_duty
   import pmd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [11:0] adc_input,
   input wire logic pulse_in,
   input wire logic [11:0] adc_feedback,
   input wire logic [7:0] adc_current,
   output logic pwm_fwd,
   output logic pwm_rev,
   output logic period_tick
);
   typedef struct packed {
      pmd_cfg_t cfg;
      pmd_bus_t bus;
      pmd_phase_t ph;
      logic [15:0] step_cnt;
      logic [7:0] ms_cnt;
      logic [11:0] raw_in;
      logic [11:0] raw_fb;
      logic [7:0] cur;
      logic [11:0] pw_cnt;
      logic [6:0] pw_acc;
      logic pulse_last;
      logic [11:0] target;
      logic [11:0] fb_scaled;
      logic signed [12:0] err;
      logic signed [12:0] err_prev;
      logic signed [23:0] integ;
      logic signed [12:0] duty_tgt;
      logic signed [12:0] duty;
      logic [9:0] pwm_cnt;
      logic pwm_fwd;
      logic pwm_rev;
      logic tick;
   } pmd_state_t;

   pmd_state_t s_q, s_d;

   // saturate a wide signed value to plus/minus a limit
   function automatic logic signed [12:0] sat(input logic signed [31:0] v,
                                               input logic signed [12:0] lim);
      logic signed [31:0] l;
      l = 32'(lim);
      if (v > l) sat = lim;
      else if (v < -l) sat = -lim;
      else sat = 13'(v);
   endfunction

   // linear scale: (raw - min) * gain / 16, clamped to 0..4095
   function automatic logic [11:0] scl(input logic [11:0] raw,
                                       input logic [11:0] mn,
                                       input logic [7:0] g);
      logic signed [31:0] t;
      t = (32'(signed'({1'b0, raw})) - 32'(signed'({1'b0, mn})))
          * 32'(signed'({1'b0, g})) >>> 4;
      if (t < 0) scl = 12'h000;
      else if (t > 32'(VAL_MAX)) scl = VAL_MAX;
      else scl = 12'(t);
   endfunction

   logic signed [31:0] pid_sum;
   logic signed [12:0] lim_max, lim_cur, step_lim, want;
   logic [8:0] cur_x;
   logic wr_hit, rd_hit;

   always_comb begin
      s_d = s_q;
      pid_sum = 32'sh0;
      lim_max = 13'sh0;
      lim_cur = 13'sh0;
      step_lim = 13'sh0;
      want = 13'sh0;
      cur_x = 9'h000;
      // writes land at the edge where the master sees waitrequest low,
      // reads load readdata one edge earlier so it stands at that edge
      wr_hit = avs_write && s_q.bus.wait_n;
      rd_hit = avs_read && s_q.bus.wait_n == 1'b0;
      s_d.tick = 1'b0;
      s_d.bus.rvalid = 1'b0;

      // one wait state, then complete the access on the next edge
      s_d.bus.wait_n = (avs_read || avs_write) && !s_q.bus.wait_n;
      if (wr_hit && avs_byteenable[0]) begin
         case (avs_address)
            OFS_CTRL: begin
               s_d.cfg.run = avs_writedata[CTRL_RUN];
               s_d.cfg.fb_en = avs_writedata[CTRL_FBEN];
               s_d.cfg.pw_mode = avs_writedata[CTRL_PWMODE];
            end
            OFS_PERIOD: s_d.cfg.period_ms = avs_writedata[7:0];
            OFS_GAIN: {s_d.cfg.kd, s_d.cfg.ki, s_d.cfg.kp} = avs_writedata[23:0];
            OFS_SCALE: {s_d.cfg.fb_gain, s_d.cfg.fb_min[3:0], s_d.cfg.in_gain,
                        s_d.cfg.in_min} = avs_writedata;
            OFS_LIMIT: {s_d.cfg.cur_lim, s_d.cfg.accel, s_d.cfg.max_duty} =
                       avs_writedata[23:0];
            OFS_TARGET: begin
               s_d.cfg.serial_tgt = avs_writedata[11:0];
               s_d.cfg.fb_min[11:4] = avs_writedata[23:16];
            end
            OFS_CURCAL: s_d.cfg.cur_cal = avs_writedata[7:0];
            default: ;
         endcase
      end
      // unmapped addresses read as zero
      if (rd_hit) begin
         case (avs_address)
            OFS_CTRL: s_d.bus.rdata = {29'h0, s_q.cfg.pw_mode, s_q.cfg.fb_en,
                                       s_q.cfg.run};
            OFS_PERIOD: s_d.bus.rdata = {24'h0, s_q.cfg.period_ms};
            OFS_GAIN: s_d.bus.rdata = {8'h0, s_q.cfg.kd, s_q.cfg.ki, s_q.cfg.kp};
            OFS_SCALE: s_d.bus.rdata = {s_q.cfg.fb_gain, s_q.cfg.fb_min[3:0],
                                        s_q.cfg.in_gain, s_q.cfg.in_min};
            OFS_LIMIT: s_d.bus.rdata = {8'h0, s_q.cfg.cur_lim, s_q.cfg.accel,
                                        s_q.cfg.max_duty};
            OFS_TARGET: s_d.bus.rdata = {8'h0, s_q.cfg.fb_min[11:4], 4'h0,
                                         s_q.cfg.serial_tgt};
            OFS_STAT0: s_d.bus.rdata = {4'h0, s_q.fb_scaled, 4'h0, s_q.target};
            OFS_STAT1: s_d.bus.rdata = {s_q.cur, 11'(s_q.duty), s_q.err};
            OFS_CURCAL: s_d.bus.rdata = {24'h0, s_q.cfg.cur_cal};
            default: s_d.bus.rdata = 32'h0;
         endcase
      end

      // samples: 12-bit raw input/feedback, 8-bit current
      s_d.raw_fb = adc_feedback;
      s_d.cur = adc_current;
      if (!s_q.cfg.pw_mode) s_d.raw_in = adc_input;

      // pulse width in 2/3 us ticks: 80 cycles per 3 ticks, saturating
      s_d.pulse_last = pulse_in;
      if (pulse_in && !s_q.pulse_last) begin
         s_d.pw_cnt = 12'h000;
         // the first high cycle counts too, or every width reads short
         s_d.pw_acc = 7'(PW_ACC_ADD);
      end else if (pulse_in) begin
         if (7'(s_q.pw_acc + 7'(PW_ACC_ADD)) >= 7'(PW_ACC_LIM)) begin
            s_d.pw_acc = 7'(s_q.pw_acc + 7'(PW_ACC_ADD) - 7'(PW_ACC_LIM));
            if (s_q.pw_cnt != VAL_MAX) s_d.pw_cnt = s_q.pw_cnt + 12'h001;
         end else begin
            s_d.pw_acc = 7'(s_q.pw_acc + 7'(PW_ACC_ADD));
         end
      end
      if (!pulse_in && s_q.pulse_last && s_q.cfg.pw_mode)
         s_d.raw_in = s_q.pw_cnt;

      // period timer: ms steps, a zero period acts as one step
      if (s_q.step_cnt == 16'(STEP_CYC - 1)) begin
         s_d.step_cnt = 16'h0000;
         if (s_q.ms_cnt + 8'h01 >= s_q.cfg.period_ms) begin
            s_d.ms_cnt = 8'h00;
            s_d.tick = 1'b1;
         end else begin
            s_d.ms_cnt = s_q.ms_cnt + 8'h01;
         end
      end else begin
         s_d.step_cnt = s_q.step_cnt + 16'h0001;
      end

      // per-period pipeline: error, pid/bypass, limits
      case (s_q.ph)
         ST_IDLE: if (s_q.tick) begin
            // target comes from scaled raw input, or serial value
            s_d.target = s_q.cfg.in_gain == 8'h00 ? s_q.cfg.serial_tgt
                         : scl(s_q.raw_in, s_q.cfg.in_min, s_q.cfg.in_gain);
            s_d.fb_scaled = scl(s_q.raw_fb, s_q.cfg.fb_min,
                                s_q.cfg.fb_gain);
            s_d.ph = ST_ERR;
         end
         ST_ERR: begin
            s_d.err_prev = s_q.err;
            s_d.err = signed'({1'b0, s_q.fb_scaled})
                      - signed'({1'b0, s_q.target});
            s_d.ph = ST_PID;
         end
         ST_PID: begin
            if (s_q.cfg.fb_en) begin
               // integral clamp avoids windup overflow
               s_d.integ = 24'(sat(32'(s_q.integ) + 32'(s_q.err),
                                   13'sh0fff));
               pid_sum = (32'(s_q.err) * 32'(signed'({1'b0, s_q.cfg.kp}))
                  + 32'(s_q.integ) * 32'(signed'({1'b0, s_q.cfg.ki}))
                  + 32'(s_q.err - s_q.err_prev)
                    * 32'(signed'({1'b0, s_q.cfg.kd}))) >>> 6;
               // error is feedback minus target, so negate for drive
               s_d.duty_tgt = sat(-pid_sum, DUTY_MAX);
            end else begin
               s_d.integ = 24'sh0;
               s_d.duty_tgt = sat(32'(signed'({1'b0, s_q.target}))
                                  - 32'(MID), DUTY_MAX);
            end
            s_d.ph = ST_LIM;
         end
         ST_LIM: begin
            // limits apply in both feedback and speed modes
            // product kept at 32 bits, 255 * 600 would wrap in 13
            lim_max = 13'((32'(s_q.cfg.max_duty) * 32'(DUTY_MAX)) >> 8);
            cur_x = {1'b0, s_q.cur};
            lim_cur = cur_x > {1'b0, s_q.cfg.cur_lim} ? 13'sh0 : DUTY_MAX;
            step_lim = signed'({5'h0, s_q.cfg.accel});
            want = sat(32'(s_q.duty_tgt), lim_max);
            want = sat(32'(want), lim_cur);
            if (want > s_q.duty + step_lim) s_d.duty = s_q.duty + step_lim;
            else if (want < s_q.duty - step_lim) s_d.duty = s_q.duty - step_lim;
            else s_d.duty = want;
            s_d.ph = ST_IDLE;
         end
         default: s_d.ph = ST_IDLE;
      endcase

      // pwm: on for |duty| of every 600 counts
      s_d.pwm_cnt = s_q.pwm_cnt == PWM_TOP - 10'h001 ? 10'h000
                    : s_q.pwm_cnt + 10'h001;
      s_d.pwm_fwd = s_q.cfg.run && s_q.duty > 13'sh0
                    && {3'h0, s_q.pwm_cnt} < 13'(s_q.duty);
      s_d.pwm_rev = s_q.cfg.run && s_q.duty < 13'sh0
                    && {3'h0, s_q.pwm_cnt} < 13'(-s_q.duty);
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.cfg.period_ms <= PERIOD_RST;
         s_q.cfg.max_duty <= MAXDUTY_RST;
         s_q.cfg.accel <= ACCEL_RST;
         s_q.cfg.cur_lim <= CURLIM_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // outputs come from the state register, waitrequest as its inverse
   assign avs_readdata = s_q.bus.rdata;
   assign avs_waitrequest = !s_q.bus.wait_n;
   assign pwm_fwd = s_q.pwm_fwd;
   assign pwm_rev = s_q.pwm_rev;
   assign period_tick = s_q.tick;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // the tick of a control period, seen with the clock enabled
   sequence tick_seen;
      clk_en && s_q.tick;
   endsequence
   // four pipeline phases and the return to idle, none frozen
   sequence calc_done;
      clk_en ##1 clk_en ##1 clk_en ##1 clk_en ##1 clk_en;
   endsequence
   sequence lim_step;
      clk_en && s_q.ph == ST_LIM;
   endsequence

   a_duty_in_range: assert property (
      s_q.duty <= DUTY_MAX && s_q.duty >= -DUTY_MAX)
      else $error("duty out of range");
   a_tgt_sat_range: assert property (
      s_q.duty_tgt <= DUTY_MAX && s_q.duty_tgt >= -DUTY_MAX)
      else $error("duty target range");
   a_off_no_drive: assert property (
      !s_q.cfg.run |=> !pwm_fwd && !pwm_rev)
      else $error("drive while off");
   a_one_direction: assert property (
      !(pwm_fwd && pwm_rev))
      else $error("both directions driven");
   a_err_formed: assert property (
      clk_en && s_q.ph == ST_ERR |=>
      s_q.err == signed'({1'b0, $past(s_q.fb_scaled)})
                 - signed'({1'b0, $past(s_q.target)}))
      else $error("error term wrong");
   // only targets that do not saturate, so the plain offset shows
   a_bypass_mid: assert property (
      clk_en && s_q.ph == ST_PID && !s_q.cfg.fb_en
      && signed'({1'b0, s_q.target}) >= MID - DUTY_MAX
      && signed'({1'b0, s_q.target}) <= MID + DUTY_MAX |=>
      s_q.duty_tgt == signed'({1'b0, $past(s_q.target)}) - MID)
      else $error("bypass offset wrong");
   a_period_pipe: assert property (
      tick_seen and calc_done |-> s_q.ph == ST_IDLE)
      else $error("pipeline not finished");
   a_fwd_sign: assert property (
      clk_en && pwm_fwd |-> $past(s_q.duty) > 0)
      else $error("forward with non-positive duty");
   a_rev_sign: assert property (
      clk_en && pwm_rev |-> $past(s_q.duty) < 0)
      else $error("reverse with non-negative duty");
   a_bus_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest && clk_en
      |=> !avs_waitrequest)
      else $error("slave answer late");
   a_wait_once: assert property (
      clk_en && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice");
   a_calc_when_off: assert property (
      tick_seen |=> s_q.ph == ST_ERR)
      else $error("calculation stopped");
   a_tick_single: assert property (
      clk_en && s_q.tick |=> !s_q.tick)
      else $error("tick longer than one cycle");
   a_integ_clear: assert property (
      clk_en && s_q.ph == ST_PID && !s_q.cfg.fb_en
      |=> s_q.integ == 24'sh0)
      else $error("integral kept in speed mode");
   // accel caps how far duty moves in one period, either way
   a_accel_step: assert property (
      lim_step |=> s_q.duty - $past(s_q.duty)
                   <= signed'({5'h0, $past(s_q.cfg.accel)})
      && $past(s_q.duty) - s_q.duty
         <= signed'({5'h0, $past(s_q.cfg.accel)}))
      else $error("duty step above accel limit");
   a_pipe_order: assert property (
      clk_en && s_q.ph == ST_PID |=> s_q.ph == ST_LIM)
      else $error("limit phase skipped");
endmodule

// File: pmd_pkg.sv
// Purpose: shared constants and carriers for the motor duty datapath
// Assumes: 40 MHz ref_clk, 32-bit Avalon-MM register port
// Notes: all offsets are byte addresses of aligned words
package pmd_pkg;
   // clock and period timing
   localparam int CLK_HZ = 40000000;
   localparam int STEP_US = 1000;
   localparam int STEP_CYC = CLK_HZ / 1000000 * STEP_US;
   localparam int TICK_NS_NUM = 2000;
   localparam int TICK_NS_DEN = 3;
   // 2/3 us tick = 80/3 cycles, done as a 3-phase accumulator of 80
   localparam int PW_ACC_ADD = 3;
   localparam int PW_ACC_LIM = CLK_HZ / 1000000 * TICK_NS_NUM / 1000;
   // value ranges
   localparam logic [11:0] VAL_MAX = 12'hfff;
   localparam logic signed [12:0] MID = 13'sh0800;
   localparam logic signed [12:0] DUTY_MAX = 13'sh0258;
   localparam logic [9:0] PWM_TOP = 10'h258;
   // register offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_PERIOD = 6'h04;
   localparam logic [5:0] OFS_GAIN = 6'h08;
   localparam logic [5:0] OFS_SCALE = 6'h0c;
   localparam logic [5:0] OFS_LIMIT = 6'h10;
   localparam logic [5:0] OFS_TARGET = 6'h14;
   localparam logic [5:0] OFS_STAT0 = 6'h18;
   localparam logic [5:0] OFS_STAT1 = 6'h1c;
   localparam logic [5:0] OFS_CURCAL = 6'h20;
   // control field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_FBEN = 1;
   localparam int CTRL_PWMODE = 2;
   // reset values
   localparam logic [7:0] PERIOD_RST = 8'h01;
   localparam logic [7:0] MAXDUTY_RST = 8'hff;
   localparam logic [7:0] ACCEL_RST = 8'hff;
   localparam logic [7:0] CURLIM_RST = 8'hff;

   typedef enum logic [1:0] {ST_IDLE, ST_ERR, ST_PID, ST_LIM} pmd_phase_t;

   // configuration written by software
   typedef struct packed {
      logic run;
      logic fb_en;
      logic pw_mode;
      logic [7:0] period_ms;
      logic [7:0] kp;
      logic [7:0] ki;
      logic [7:0] kd;
      logic [11:0] in_min;
      logic [7:0] in_gain;
      logic [11:0] fb_min;
      logic [7:0] fb_gain;
      logic [7:0] max_duty;
      logic [7:0] accel;
      logic [7:0] cur_lim;
      logic [11:0] serial_tgt;
      logic [7:0] cur_cal;
   } pmd_cfg_t;

   // bus-side response carrier
   typedef struct packed {
      logic [31:0] rdata;
      logic rvalid;
      logic wait_n;
   } pmd_bus_t;
endpackage

// File: pmd_motor_model.sv
// Purpose: power stage and sensor seen from the duty block's drive pins
// Assumes: drive levels are sampled on ref_clk
// Notes: feedback and current are bench settings, not a motor law
`timescale 1ns/1ps
module pmd_motor_model (
   input wire logic ref_clk,
   input wire logic clr,
   input wire logic pwm_fwd,
   input wire logic pwm_rev,
   input wire logic [11:0] fb_set,
   input wire logic [7:0] cur_set,
   output logic [11:0] adc_feedback,
   output logic [7:0] adc_current,
   output logic [15:0] fwd_cnt,
   output logic [15:0] rev_cnt,
   output logic both_seen
);
   // fixed sensor values keep the error term predictable
   assign adc_feedback = fb_set;
   assign adc_current = cur_set;
   // bridge on-time per direction, cleared by the bench per window
   always @(posedge ref_clk) begin
      if (clr) begin
         fwd_cnt <= 16'h0000;
         rev_cnt <= 16'h0000;
      end else begin
         fwd_cnt <= fwd_cnt + {15'h0000, pwm_fwd};
         rev_cnt <= rev_cnt + {15'h0000, pwm_rev};
      end
   end
   // both legs on would short the supply, so it is latched for the bench
   logic seen_q = 1'b0;
   always @(posedge ref_clk) begin
      seen_q <= seen_q | (pwm_fwd & pwm_rev);
   end
   assign both_seen = seen_q;
endmodule

// File: pid_motor_duty_computation_tb_top.sv
// Purpose: self-checking bench for the per-period duty datapath
// Assumes: one wait state per bus access, 40000 cycles per ms
// Notes: only two control periods fit the run, so accel never binds
`timescale 1ns/1ps
module pid_motor_duty_computation_tb_top import pmd_pkg::*;;
   logic ref_clk, arst_n, clk_en, avs_read, avs_write, pulse_in;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, seed, tick1;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest, pwm_fwd, pwm_rev, period_tick, clr, both_seen;
   logic [11:0] adc_input, adc_feedback, fb_set;
   logic [7:0] adc_current, cur_set;
   logic [15:0] fwd_cnt, rev_cnt;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int err_count, compares, cyc, tick_at;

   pmd_duty u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .adc_input(adc_input),
      .pulse_in(pulse_in), .adc_feedback(adc_feedback),
      .adc_current(adc_current), .pwm_fwd(pwm_fwd), .pwm_rev(pwm_rev),
      .period_tick(period_tick));
   pmd_motor_model u_motor (.ref_clk(ref_clk), .clr(clr),
      .pwm_fwd(pwm_fwd), .pwm_rev(pwm_rev), .fb_set(fb_set),
      .cur_set(cur_set), .adc_feedback(adc_feedback),
      .adc_current(adc_current), .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt),
      .both_seen(both_seen));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask
   // master holds the request until waitrequest is sampled low
   task automatic bus_go(input logic [5:0] a, input logic wr,
                         input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus_go(a, 1'b0, 32'h0, 4'hf);
   endtask
   // duty changes 4 cycles after the tick, so settle a few cycles more
   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (period_tick !== 1'b1 && n < 50000);
      tick_at = cyc;
      repeat (8) @(posedge ref_clk);
   endtask
   // one full pwm period of 600 cycles sees every on-cycle exactly once
   task automatic pwm_win(input logic [15:0] ef, input logic [15:0] er);
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (600) @(posedge ref_clk);
      #1;
      chk("fwd on-time", {16'h0, ef}, {16'h0, fwd_cnt});
      chk("rev on-time", {16'h0, er}, {16'h0, rev_cnt});
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // completed reads retire the oldest note in order
   always @(posedge ref_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0)
            chk("unexpected read", 32'h0, 32'hffffffff);
         else
            chk("readdata", exp_q.pop_front(),
                avs_readdata & msk_q.pop_front());
      end
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #2500000;
      err_count++;
      summarize();
   end
   initial begin
      {arst_n, avs_read, avs_write, pulse_in, clr} = 5'h00;
      clk_en = 1'b1;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      fb_set = 12'h3e8;
      err_count = 0;
      compares = 0;
      cyc = 0;
      seed = xs(32'hfc2);
      adc_input = seed[11:0];
      cur_set = seed[19:12] & 8'hfe;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(OFS_PERIOD, 32'h1, 32'hffffffff);
      rd(OFS_LIMIT, 32'h00ffffff, 32'hffffffff);
      rd(6'h3c, 32'h0, 32'hffffffff);
      bus_go(OFS_PERIOD, 1'b1, 32'h5, 4'he);
      rd(OFS_PERIOD, 32'h1, 32'hffffffff);
      $display("test registers done");
      // pulse-width input, in_gain 180, feedback off, drive off
      bus_go(OFS_CTRL, 1'b1, 32'h4, 4'hf);
      bus_go(OFS_SCALE, 1'b1, 32'h100b4000, 4'hf);
      bus_go(OFS_GAIN, 1'b1, 32'h0, 4'hf);
      bus_go(OFS_TARGET, 1'b1, 32'h8c8, 4'hf);
      // 5340 cycles of 25 ns are 200.25 units of 2/3 us: raw input 200
      @(posedge ref_clk);
      pulse_in <= 1'b1;
      repeat (5340) @(posedge ref_clk);
      pulse_in <= 1'b0;
      wait_tick();
      tick1 = tick_at;
      // target 200 * 180 / 16 = 2250, bypass duty 2250 - 2048 = 202
      rd(OFS_STAT0, 32'h8ca, 32'h00000fff);
      rd(OFS_STAT1, {cur_set, 11'd202, 13'h0}, 32'hffffe000);
      pwm_win(16'h0, 16'h0);
      $display("test speed mode off done");
      bus_go(OFS_GAIN, 1'b1, 32'h1, 4'hf);
      bus_go(OFS_TARGET, 1'b1, 32'h668, 4'hf);
      bus_go(OFS_SCALE, 1'b1, 32'h10000000, 4'hf);
      bus_go(OFS_CTRL, 1'b1, 32'h3, 4'hf);
      wait_tick();
      chk("period", 32'd40000, tick_at - tick1);
      rd(OFS_STAT0, 32'h03e80668, 32'h0fff0fff);
      rd(OFS_STAT1, {cur_set, 11'd10, 13'h1d80}, 32'hffffffff);
      pwm_win(16'ha, 16'h0);
      chk("both legs", 32'h0, {31'h0, both_seen});
      $display("test pid run done");
      summarize();
   end
endmodule
